// [core/ssp_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module ssp_dev #(
    parameter bit ALT_ADDR    = 1'b0,
    parameter int TIMEOUT_CYC = ssp_pkg::TIMEOUT_CYC
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_b,
    ssp_if.dev        bus,
    input  wire logic i_limit_event,
    input  wire logic i_open_event,
    input  wire logic i_cond_active,
    output logic      o_timeout_en,
    output logic [7:0] o_status
);
    initial begin
        if (TIMEOUT_CYC < 1) $error("bad timeout");
    end
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001, ST_ADDR = 5'b00010, ST_RX = 5'b00100,
        ST_TX = 5'b01000, ST_IGN = 5'b10000
    } ssp_dst_type;
    localparam logic [6:0] MY_ADDR = ALT_ADDR ? ssp_pkg::ADDR_ALT : ssp_pkg::ADDR_STD;

    // ====================
    // synchronisers
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_d;
    logic       sda_d;
    always_ff @(posedge i_sys_clk) begin
        scl_s <= {scl_s[0], bus.scl};
        sda_s <= {sda_s[0], bus.serial_data_line};
        scl_d <= scl_s[1];
        sda_d <= sda_s[1];
    end
    wire scl_rise = scl_s[1] && !scl_d;
    wire scl_fall = !scl_s[1] && scl_d;
    wire start_c  = scl_s[1] && scl_d && sda_d && !sda_s[1];
    wire stop_c   = scl_s[1] && scl_d && !sda_d && sda_s[1];

    // ====================
    // timeout
    logic [31:0] quiet_reg;
    logic        to_hit;
    logic [7:0]  filt_reg;
    assign to_hit = filt_reg[ssp_pkg::FILT_TO_BIT] && (quiet_reg >= 32'(TIMEOUT_CYC));
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || scl_rise || scl_fall || start_c || stop_c) quiet_reg <= 32'h0;
        else if (!to_hit) quiet_reg <= quiet_reg + 32'h1;
    end

    // ====================
    // byte engine
    ssp_dst_type st_reg;
    logic [3:0]  bit_reg;
    logic [7:0]  sh_reg;
    logic        rd_reg;
    logic        ara_reg;
    logic [1:0]  nbyte_reg;
    logic [7:0]  ptr_reg;
    logic [7:0]  scratch_reg;
    logic [7:0]  stat_reg;
    logic        sda_o_reg;
    logic        sda_oe_reg;
    logic        alert_reg;
    logic        lost_reg;
    logic        addr_ack_reg;

    // high between the last address bit and the address acknowledge clock
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || start_c) addr_ack_reg <= 1'b0;
        else if (scl_rise) addr_ack_reg <= (st_reg == ST_ADDR && bit_reg == 4'h7);
    end

    function automatic logic [7:0] rd_mux(input logic [7:0] p);
        unique case (p)
            ssp_pkg::OFS_STATUS:    rd_mux = stat_reg;
            ssp_pkg::OFS_SCRATCH_R: rd_mux = scratch_reg;
            ssp_pkg::OFS_FILT:      rd_mux = filt_reg;
            default:                rd_mux = ssp_pkg::UNMAPPED_DATA;
        endcase
    endfunction

    wire [7:0] rx_byte = sh_reg;
    wire ack_phase = (bit_reg == 4'h8);
    logic stat_read;
    logic wr_strobe;
    assign stat_read = (st_reg == ST_TX) && !ara_reg && scl_rise && (bit_reg == 4'h0)
                       && (ptr_reg == ssp_pkg::OFS_STATUS);
    assign wr_strobe = (st_reg == ST_RX) && scl_rise && (bit_reg == 4'h7) && (nbyte_reg == 2'h1);

    // start outranks a stale timeout, else a saturated quiet count would swallow it
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_reg <= ST_IDLE;
            bit_reg <= 4'h0;
        end else if (start_c) begin
            st_reg <= ST_ADDR;
            bit_reg <= 4'h0;
        end else if (to_hit || stop_c) begin
            st_reg <= ST_IDLE;
            bit_reg <= 4'h0;
        end else if (scl_rise && st_reg != ST_IDLE && st_reg != ST_IGN) begin
            if (bit_reg == 4'h8) begin
                bit_reg <= 4'h0;
                if (st_reg == ST_TX && sda_s[1]) st_reg <= ST_IGN;
            end else begin
                bit_reg <= bit_reg + 4'h1;
            end
            if (st_reg == ST_ADDR && bit_reg == 4'h7) begin
                if ({sh_reg[6:0]} == MY_ADDR) st_reg <= sda_s[1] ? ST_TX : ST_RX;
                else if (sh_reg[6:0] == ssp_pkg::ADDR_ARA && sda_s[1] && alert_reg) st_reg <= ST_TX;
                else st_reg <= ST_IGN;
            end
            if (st_reg == ST_TX && lost_reg) st_reg <= ST_IGN;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || start_c) begin
            sh_reg <= 8'h0;
            rd_reg <= 1'b0;
            ara_reg <= 1'b0;
            nbyte_reg <= 2'h0;
        end else if (scl_rise && !ack_phase) begin
            sh_reg <= {sh_reg[6:0], sda_s[1]};
            if (st_reg == ST_ADDR && bit_reg == 4'h7) begin
                rd_reg <= sda_s[1];
                ara_reg <= (sh_reg[6:0] == ssp_pkg::ADDR_ARA);
            end
            if (st_reg == ST_RX && bit_reg == 4'h7 && nbyte_reg != 2'h3) nbyte_reg <= nbyte_reg + 2'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) ptr_reg <= 8'h0;
        else if (st_reg == ST_RX && scl_rise && bit_reg == 4'h7 && nbyte_reg == 2'h0)
            ptr_reg <= {sh_reg[6:0], sda_s[1]};
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            filt_reg <= ssp_pkg::FILT_RST;
            scratch_reg <= ssp_pkg::SCRATCH_RST;
        end else if (wr_strobe) begin
            if (ptr_reg == ssp_pkg::OFS_FILT) filt_reg <= {sh_reg[6:0], sda_s[1]};
            if (ptr_reg == ssp_pkg::OFS_SCRATCH_W) scratch_reg <= {sh_reg[6:0], sda_s[1]};
        end
    end

    // ====================
    // status flags and alert; set wins over read-clear
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) stat_reg <= 8'h0;
        else stat_reg <= (stat_read ? 8'h0 : stat_reg) | {3'h0, i_limit_event, 1'b0, i_open_event, 2'h0};
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) alert_reg <= 1'b0;
        else if (i_limit_event || i_open_event) alert_reg <= 1'b1;
        else if (st_reg == ST_TX && ara_reg && scl_rise && bit_reg == 4'h8 && !lost_reg
                 && !i_cond_active && stat_reg == 8'h0) alert_reg <= 1'b0;
    end

    // ====================
    // data drive, changed on falling clock edge
    wire [7:0] tx_byte = ara_reg ? {MY_ADDR, 1'b1} : rd_mux(ptr_reg);
    logic [7:0] txsh_reg;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || start_c) lost_reg <= 1'b0;
        else if (st_reg == ST_TX && ara_reg && scl_rise && bit_reg < 4'h8 && !sda_oe_reg && !sda_s[1])
            lost_reg <= 1'b1;
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || to_hit || stop_c || start_c) begin
            sda_o_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
            txsh_reg <= 8'h0;
        end else if (scl_fall) begin
            sda_o_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
            if (st_reg == ST_ADDR && bit_reg == 4'h8 && st_reg != ST_IGN) begin
                sda_o_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
            end
            if ((st_reg == ST_RX || (st_reg == ST_TX && addr_ack_reg)) && bit_reg == 4'h8) begin
                sda_o_reg <= 1'b0;
                sda_oe_reg <= (st_reg == ST_RX) ? (nbyte_reg != 2'h3) : 1'b1;
                txsh_reg <= tx_byte;
            end else if (st_reg == ST_TX && bit_reg < 4'h8 && !lost_reg) begin
                sda_o_reg <= txsh_reg[3'(7 - bit_reg)];
                sda_oe_reg <= !txsh_reg[3'(7 - bit_reg)];
            end
        end
    end

    assign bus.sda_dev_o  = sda_o_reg;
    assign bus.sda_dev_oe = sda_oe_reg;
    assign bus.alert_o    = 1'b0;
    assign bus.alert_oe   = alert_reg;
    always_ff @(posedge i_sys_clk) begin
        o_timeout_en <= i_rst_b && filt_reg[ssp_pkg::FILT_TO_BIT];
        o_status     <= i_rst_b ? stat_reg : 8'h0;
    end
endmodule
`default_nettype wire

// [core/ssp_mst.sv]
`timescale 1ns/1ps
`default_nettype none
module ssp_mst #(
    parameter int DIV = ssp_pkg::MST_DIV
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    ssp_if.mst               bus,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);
    initial begin
        if (DIV < 2) $error("bad divider");
    end
    // cmd word: [6:0] addr, [7] read, [9:8] nbytes, [23:16] byte0, [31:24] byte1
    typedef enum logic [3:0] {
        MS_IDLE = 4'b0001, MS_START = 4'b0010, MS_BYTE = 4'b0100, MS_STOP = 4'b1000
    } ssp_mst_type;
    logic [1:0] sda_s;
    logic [1:0] alr_s;
    always_ff @(posedge i_sys_clk) begin
        sda_s <= {sda_s[0], bus.serial_data_line};
        alr_s <= {alr_s[0], bus.alert_line};
    end
    logic [7:0]  div_reg;
    logic        tick;
    assign tick = (div_reg == 8'(DIV - 1));
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || tick) div_reg <= 8'h0;
        else div_reg <= div_reg + 8'h1;
    end
    ssp_mst_type st_reg;
    logic [1:0]  ph_reg;
    logic [3:0]  bit_reg;
    logic [1:0]  idx_reg;
    logic [31:0] cmd_reg;
    logic [8:0]  sh_reg;
    logic [7:0]  rx_reg;
    logic        nak_reg;
    logic        scl_reg;
    logic        sda_reg;
    logic        wait_reg;
    wire busy = (st_reg != MS_IDLE);
    wire [1:0] nbytes = cmd_reg[7] ? 2'h1 : cmd_reg[9:8];
    function automatic logic [8:0] load_byte(input logic [1:0] i, input logic [31:0] c);
        unique case (i)
            2'h0:    load_byte = {c[6:0], c[7], 1'b1};
            2'h1:    load_byte = c[7] ? 9'h1FF : {c[23:16], 1'b1};
            default: load_byte = {c[31:24], 1'b1};
        endcase
    endfunction
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            st_reg <= MS_IDLE; ph_reg <= 2'h0; bit_reg <= 4'h0; idx_reg <= 2'h0;
            cmd_reg <= 32'h0; sh_reg <= 9'h1FF; rx_reg <= 8'h0; nak_reg <= 1'b0;
            scl_reg <= 1'b1; sda_reg <= 1'b1;
        end else if (st_reg == MS_IDLE) begin
            if (i_avs_write && !wait_reg && i_avs_address == ssp_pkg::HOFS_CMD) begin
                cmd_reg <= i_avs_writedata;
                st_reg <= MS_START;
                ph_reg <= 2'h0;
                nak_reg <= 1'b0;
            end
        end else if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            unique case (st_reg)
                MS_START: begin
                    if (ph_reg == 2'h1) sda_reg <= 1'b0;
                    if (ph_reg == 2'h3) begin
                        scl_reg <= 1'b0; st_reg <= MS_BYTE; bit_reg <= 4'h0; idx_reg <= 2'h0;
                        sh_reg <= load_byte(2'h0, cmd_reg);
                    end
                end
                MS_BYTE: begin
                    if (ph_reg == 2'h0) sda_reg <= (idx_reg != 2'h0 && cmd_reg[7] && bit_reg == 4'h8) ? 1'b1 : sh_reg[8];
                    if (ph_reg == 2'h1) scl_reg <= 1'b1;
                    if (ph_reg == 2'h2) begin
                        if (bit_reg < 4'h8) rx_reg <= {rx_reg[6:0], sda_s[1]};
                        else if (sda_s[1] && !(cmd_reg[7] && idx_reg != 2'h0)) nak_reg <= 1'b1;
                    end
                    if (ph_reg == 2'h3) begin
                        scl_reg <= 1'b0;
                        sh_reg <= {sh_reg[7:0], 1'b1};
                        if (bit_reg == 4'h8) begin
                            bit_reg <= 4'h0;
                            if (idx_reg == nbytes || nak_reg) st_reg <= MS_STOP;
                            else begin
                                idx_reg <= idx_reg + 2'h1;
                                sh_reg <= load_byte(idx_reg + 2'h1, cmd_reg);
                            end
                        end else bit_reg <= bit_reg + 4'h1;
                    end
                end
                MS_STOP: begin
                    if (ph_reg == 2'h0) sda_reg <= 1'b0;
                    if (ph_reg == 2'h1) scl_reg <= 1'b1;
                    if (ph_reg == 2'h3) begin
                        sda_reg <= 1'b1; st_reg <= MS_IDLE;
                    end
                end
                default: st_reg <= MS_IDLE;
            endcase
        end
    end
    assign bus.scl_o      = 1'b0;
    assign bus.scl_oe     = !scl_reg;
    assign bus.sda_mst_o  = 1'b0;
    assign bus.sda_mst_oe = !sda_reg;
    // one wait cycle per access; command writes stall while busy
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) wait_reg <= 1'b1;
        else if (wait_reg && (i_avs_read || (i_avs_write && !busy))) wait_reg <= 1'b0;
        else wait_reg <= 1'b1;
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) o_avs_readdata <= 32'h0;
        else if (i_avs_read && wait_reg) begin
            unique case (i_avs_address)
                ssp_pkg::HOFS_DATA: o_avs_readdata <= {24'h0, rx_reg};
                ssp_pkg::HOFS_STAT: o_avs_readdata <= {29'h0, !alr_s[1], nak_reg, busy};
                default:            o_avs_readdata <= cmd_reg;
            endcase
        end
    end
    assign o_avs_waitrequest = wait_reg;
endmodule
`default_nettype wire

// [include/ssp_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ssp_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_mst_o;
    logic sda_mst_oe;
    logic alert_o;
    logic alert_oe;
    logic scl;
    logic serial_data_line;
    logic alert_line;
    assign scl              = !(scl_oe && !scl_o);
    assign serial_data_line = !((sda_dev_oe && !sda_dev_o) || (sda_mst_oe && !sda_mst_o));
    assign alert_line       = !(alert_oe && !alert_o);
    modport dev (input scl, serial_data_line, output sda_dev_o, sda_dev_oe, alert_o, alert_oe);
    modport mst (input scl, serial_data_line, alert_line, output scl_o, scl_oe, sda_mst_o, sda_mst_oe);
endinterface
`default_nettype wire

// [include/ssp_pkg.sv]
// Function
// - timeout enabled: idle after 25 ms quiet
// - timeout off at reset; bit7 of 0x22
// - standard variant answers address 0x4C and, while alert is low, ARA
// - alternate variant answers address 0x4D
// - master sends address MSB first, then direction
// - acknowledge address match by pulling data low
// - direction zero writes, one reads
// - nine clock pulses per byte
// - master changes data only while clock low
// - master ends read: nack then stop
// - one direction per transaction
// - writes one or two bytes, reads one
// - first write byte loads register pointer
// - second write byte stored at pointer
// - read returns register at current pointer
// - separate read/write offsets need matching pointer
// - alert pin low on limit or open sensor
// - while alert low answer ARA with address
// - lower address wins alert arbitration
// - release alert only when condition cleared
// - master repeats ARA while alert line low; ssp_mst only reports the alert line in its status, the host reissues ARA
// - latched flags stay until status read
package ssp_pkg;
    localparam logic [6:0] ADDR_STD      = 7'h4C;
    localparam logic [6:0] ADDR_ALT      = 7'h4D;
    localparam logic [6:0] ADDR_ARA      = 7'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h02;
    localparam logic [7:0] OFS_FILT      = 8'h22;
    localparam logic [7:0] OFS_SCRATCH_R = 8'h03;
    localparam logic [7:0] OFS_SCRATCH_W = 8'h09;
    localparam int         FILT_TO_BIT   = 7;
    localparam logic [7:0] FILT_RST      = 8'h01;
    localparam logic [7:0] SCRATCH_RST   = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam int         CLK_MHZ       = 125;
    localparam int         TIMEOUT_MS    = 25;
    localparam int         TIMEOUT_CYC   = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int         MST_DIV       = 5;
    // host command registers
    localparam logic [3:0] HOFS_CMD      = 4'h0;
    localparam logic [3:0] HOFS_DATA     = 4'h4;
    localparam logic [3:0] HOFS_STAT     = 4'h8;
endpackage

// [verif/ssp_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ssp_properties (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic scl,
    input wire logic serial_data_line,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_mst_oe,
    input wire logic alert_o,
    input wire logic alert_oe
);
    // ==========================================
    // bus tracking
    logic       scl_reg;
    logic       sda_reg;
    logic [4:0] bit_cnt_reg;
    logic [7:0] first_byte_reg;
    logic       acked_reg;
    logic       rise;
    logic       start;
    logic       stop;
    assign rise  = scl && !scl_reg;
    assign start = scl && scl_reg && sda_reg && !serial_data_line;
    assign stop  = scl && scl_reg && !sda_reg && serial_data_line;
    // idle level on reset so release never looks like an edge
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            scl_reg <= 1'h1;
            sda_reg <= 1'h1;
        end else begin
            scl_reg <= scl;
            sda_reg <= serial_data_line;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b || start) begin
            bit_cnt_reg    <= 5'h00;
            first_byte_reg <= 8'h00;
            acked_reg      <= 1'h0;
        end else if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h08) begin
                acked_reg <= !serial_data_line;
            end
            if (bit_cnt_reg < 5'h08) begin
                first_byte_reg <= {first_byte_reg[6:0], serial_data_line};
            end
        end
    end
    // ==========================================
    // properties
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    property p_ack_own; rise && bit_cnt_reg == 5'h08 && first_byte_reg[7:1] == ssp_pkg::ADDR_STD |-> sda_dev_oe; endproperty
    a_ack_own: assert property (p_ack_own) else $error("own address not acknowledged");
    property p_no_ack_other;
        rise && bit_cnt_reg == 5'h08 && first_byte_reg[7:1] != ssp_pkg::ADDR_STD
            && first_byte_reg[7:1] != ssp_pkg::ADDR_ARA |-> !sda_dev_oe;
    endproperty
    a_no_ack_other: assert property (p_no_ack_other) else $error("foreign address acknowledged");
    property p_ara_ack; rise && bit_cnt_reg == 5'h08 && first_byte_reg == {ssp_pkg::ADDR_ARA, 1'h1} && alert_oe |-> sda_dev_oe; endproperty
    a_ara_ack: assert property (p_ara_ack) else $error("alert response not acknowledged");
    property p_addr_quiet; rise && bit_cnt_reg < 5'h08 |-> !sda_dev_oe; endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address");
    property p_stop_count; stop |-> bit_cnt_reg == 5'h0A || bit_cnt_reg == 5'h13 || bit_cnt_reg == 5'h1C; endproperty
    a_stop_count: assert property (p_stop_count) else $error("stop not after whole bytes");
    property p_read_nack; rise && bit_cnt_reg == 5'h11 && first_byte_reg[0] |-> !sda_mst_oe; endproperty
    a_read_nack: assert property (p_read_nack) else $error("master acknowledged last read byte");
    property p_read_dir;
        rise && acked_reg && bit_cnt_reg > 5'h08 && bit_cnt_reg < 5'h11 && first_byte_reg[0] |-> !sda_mst_oe;
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("master drove read data");
    property p_write_dir;
        rise && bit_cnt_reg > 5'h08 && bit_cnt_reg != 5'h11 && bit_cnt_reg != 5'h1A && !first_byte_reg[0] |-> !sda_dev_oe;
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("device drove write data");
    property p_stable_high; scl && scl_reg && serial_data_line != sda_reg |-> sda_mst_oe != $past(sda_mst_oe); endproperty
    a_stable_high: assert property (p_stable_high) else $error("data moved while clock high");
    property p_open_drain; (sda_dev_oe |-> !sda_dev_o) and (alert_oe |-> !alert_o); endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk;
    logic        rst_b;
    logic [3:0]  av_addr;
    logic        av_rd;
    logic        av_wr;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic        lim_ev;
    logic        open_ev;
    logic        cond;
    logic        to_en;
    logic [7:0]  status;
    int          n_mismatch;
    int          n_compared;
    ssp_if bus ();
    ssp_dev #(.ALT_ADDR(1'h0), .TIMEOUT_CYC(2000)) u_ssp_dev (.i_sys_clk(clk), .i_rst_b(rst_b), .bus(bus),
        .i_limit_event(lim_ev), .i_open_event(open_ev), .i_cond_active(cond), .o_timeout_en(to_en), .o_status(status));
    ssp_mst u_ssp_mst (.i_sys_clk(clk), .i_rst_b(rst_b), .bus(bus), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait));
    ssp_properties u_ssp_properties (.i_sys_clk(clk), .i_rst_b(rst_b), .scl(bus.scl),
        .serial_data_line(bus.serial_data_line), .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe),
        .sda_mst_oe(bus.sda_mst_oe), .alert_o(bus.alert_o), .alert_oe(bus.alert_oe));
    // ==========================================
    // common tasks
    task automatic report_and_stop();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        n_mismatch++;
        $display("[FAIL] %0t %s timed out", $time, what);
        report_and_stop();
    endtask
    task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        int i;
        @(posedge clk);
        av_addr  <= a;
        av_rd    <= rd;
        av_wr    <= !rd;
        av_wdata <= wd;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (av_wait === 1'h0) break;
        end
        if (i == 100) hang("bus access");
        rdat = av_rdata;
        av_rd <= 1'h0;
        av_wr <= 1'h0;
    endtask
    // one bus transaction; status bits: nack, alert low
    task automatic xfer(input logic [31:0] cmd, output logic [7:0] data, output logic [2:0] st);
        logic [31:0] r;
        int          k;
        av(1'h0, ssp_pkg::HOFS_CMD, cmd, r);
        for (k = 0; k < 2000; k++) begin
            av(1'h1, ssp_pkg::HOFS_STAT, 32'h0, r);
            if (r[0] === 1'h0) break;
        end
        if (k == 2000) hang("transaction");
        st = r[2:0];
        av(1'h1, ssp_pkg::HOFS_DATA, 32'h0, r);
        data = r[7:0];
    endtask
    function automatic logic [31:0] wcmd(input logic [7:0] p, input logic [7:0] d, input logic [1:0] n);
        return {d, p, 6'h00, n, 1'h0, ssp_pkg::ADDR_STD};
    endfunction
    function automatic logic [31:0] rcmd(input logic [6:0] a);
        return {24'h000000, 1'h1, a};
    endfunction
    task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
        logic [2:0] st;
        xfer(wcmd(p, 8'h00, 2'h1), d, st);
        xfer(rcmd(ssp_pkg::ADDR_STD), d, st);
    endtask
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] x;
        logic [2:0] st;
        xfer(wcmd(p, d, 2'h2), x, st);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        logic [7:0] d;
        check(bus.scl & bus.serial_data_line & bus.alert_line, 32'h1, "bus not idle");
        check(to_en, 32'h0, "timeout on at reset");
        rd_reg(ssp_pkg::OFS_FILT, d);
        check(d, ssp_pkg::FILT_RST, "filter reset value");
    endtask
    task automatic t_scratch();
        logic [7:0] d;
        logic [2:0] st;
        wr_reg(ssp_pkg::OFS_SCRATCH_W, 8'hA5);
        rd_reg(ssp_pkg::OFS_SCRATCH_R, d);
        check(d, 8'hA5, "scratch readback");
        xfer(rcmd(ssp_pkg::ADDR_STD), d, st);
        check(d, 8'hA5, "read at held pointer");
        rd_reg(8'h10, d);
        check(d, ssp_pkg::UNMAPPED_DATA, "unmapped read");
        rd_reg(ssp_pkg::OFS_SCRATCH_R, d);
        check(d, 8'hA5, "scratch disturbed");
        xfer(rcmd(ssp_pkg::ADDR_ALT), d, st);
        check(st[1], 32'h1, "other address acknowledged");
    endtask
    task automatic t_timeout_bit();
        logic [7:0] d;
        wr_reg(ssp_pkg::OFS_FILT, 8'h81);
        check(to_en, 32'h1, "timeout enable");
        rd_reg(ssp_pkg::OFS_FILT, d);
        check(d, 8'h81, "filter readback");
    endtask
    task automatic t_alert(input bit use_open, input logic [7:0] flag);
        logic [7:0] d;
        logic [2:0] st;
        @(posedge clk);
        cond    <= 1'h1;
        lim_ev  <= !use_open;
        open_ev <= use_open;
        @(posedge clk);
        lim_ev  <= 1'h0;
        open_ev <= 1'h0;
        repeat (2) @(posedge clk);
        check(status, flag, "latched flag");
        check(bus.alert_line, 32'h0, "alert not low");
        xfer(rcmd(ssp_pkg::ADDR_ARA), d, st);
        check(d, {ssp_pkg::ADDR_STD, 1'h1}, "alert response data");
        check(st[2], 32'h1, "alert released while active");
        cond <= 1'h0;
        xfer(rcmd(ssp_pkg::ADDR_ARA), d, st);
        check(st[2], 32'h1, "alert released before status read");
        rd_reg(ssp_pkg::OFS_STATUS, d);
        check(d, flag, "status read");
        check(status, 32'h0, "status not cleared");
        xfer(rcmd(ssp_pkg::ADDR_ARA), d, st);
        check(bus.alert_line, 32'h1, "alert held after service");
    endtask
    // ==========================================
    // main sequence
    initial begin
        clk = 1'h0;
        forever #4 clk = !clk;
    end
    initial begin
        rst_b    = 1'h0;
        av_addr  = 4'h0;
        av_rd    = 1'h0;
        av_wr    = 1'h0;
        av_wdata = 32'h0;
        lim_ev   = 1'h0;
        open_ev  = 1'h0;
        cond     = 1'h0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        t_reset();
        t_scratch();
        t_timeout_bit();
        t_alert(1'h0, 8'h10);
        t_alert(1'h1, 8'h04);
        report_and_stop();
    end
endmodule
`default_nettype wire
